/* hw/ufd_defs.svh */
// offsets, field positions, reset values and levels of the fifo control shadows
// How it works
// - dma mode field has own shadow bit
// - dma mode write leaves other fields alone
// - dma mode picks request scheme, 0 or 1
// - fifo enable field has own shadow bit
// - fifo enable write leaves other fields alone
// - fifo enable turns both fifos on or off
// - disabling enabled fifos flushes both controllers
// - rx trigger field has two-bit shadow
// - rx trigger write leaves other fields alone
// - rx trigger sets data-available interrupt level
// - in mode 1 trigger drives rx request
// - trigger codes: one, quarter, half, full-2
// - shadows reset to zero, reserved bits zero
`ifndef UFD_DEFS_SVH
`define UFD_DEFS_SVH

// byte addresses on the peripheral bus
`define UFD_A_DMA_MODE  32'h5000_1094
`define UFD_A_FIFO_EN   32'h5000_1098
`define UFD_A_RX_TRIG   32'h5000_109C
`define UFD_A_CTRL      32'h5000_10E0
`define UFD_A_INT_STAT  32'h5000_10E4
`define UFD_A_INT_MASK  32'h5000_10E8

// field positions in the full control image
`define UFD_FE_BIT      0
`define UFD_DMAM_BIT    3
`define UFD_TRIG_MSB    7
`define UFD_TRIG_LSB    6

// interrupt status bits
`define UFD_INT_LEVEL   0
`define UFD_INT_FLUSH   1

// reset values
`define UFD_RST_DMA     1'h0
`define UFD_RST_FE      1'h0
`define UFD_RST_TRIG    2'h0
`define UFD_RST_MASK    2'h0

// fifo depth and the four fill levels
`define UFD_DEPTH       5'h10
`define UFD_LVL_ONE     5'h01
`define UFD_LVL_QTR     5'h04
`define UFD_LVL_HALF    5'h08
`define UFD_LVL_NFULL   5'h0E

`endif

/* hw/ufd_pkg.sv */
// types shared by the fifo control shadow block
package ufd_pkg;

    typedef logic [4:0] ufd_cnt_t;

    typedef enum logic {
        UFD_MODE0 = 1'b0,
        UFD_MODE1 = 1'b1
    } ufd_dma_mode_t;

    typedef enum logic [1:0] {
        UFD_TRIG_ONE   = 2'h0,
        UFD_TRIG_QTR   = 2'h1,
        UFD_TRIG_HALF  = 2'h2,
        UFD_TRIG_NFULL = 2'h3
    } ufd_trig_t;

    typedef enum logic [1:0] {
        UFD_REQ_IDLE = 2'b01,
        UFD_REQ_ON   = 2'b10
    } ufd_req_state_t;

    typedef struct packed {
        ufd_req_state_t state;
        logic           req_n;
    } ufd_req_st_t;

    typedef struct packed {
        ufd_dma_mode_t dma_mode;
        logic          fifo_en;
        ufd_trig_t     rx_trig;
        logic          fifo_flush;
        logic [1:0]    int_status;
        logic [1:0]    int_mask;
        logic          irq;
        logic          rx_avail;
        logic          was_level;
        logic          pready;
        logic          pslverr;
        logic [31:0]   prdata;
    } ufd_regs_t;

endpackage : ufd_pkg

/* hw/ufd_dma_if.sv */
// conditions into, and request out of, one dma request generator
`timescale 1ns/10ps
interface ufd_dma_if;
    ufd_pkg::ufd_dma_mode_t mode;
    logic                   m0_set;
    logic                   m0_drop;
    logic                   m1_set;
    logic                   m1_drop;
    logic                   req_n;

    modport ctl (output mode, output m0_set, output m0_drop,
                 output m1_set, output m1_drop, input req_n);
    modport gen (input mode, input m0_set, input m0_drop,
                 input m1_set, input m1_drop, output req_n);
endinterface : ufd_dma_if

/* hw/ufd_rx_level.sv */
// receive fill threshold and level compare
`timescale 1ns/10ps
`include "ufd_defs.svh"
module ufd_rx_level (
    input  wire ufd_pkg::ufd_trig_t trig,
    input  wire logic               fifo_en,
    input  wire ufd_pkg::ufd_cnt_t  count,
    output ufd_pkg::ufd_cnt_t       threshold,
    output logic                    at_level
);
    import ufd_pkg::*;

    // decode of the trigger code into a character count
    always_comb begin
        unique case (trig)
            UFD_TRIG_ONE:   threshold = `UFD_LVL_ONE;
            UFD_TRIG_QTR:   threshold = `UFD_LVL_QTR;
            UFD_TRIG_HALF:  threshold = `UFD_LVL_HALF;
            UFD_TRIG_NFULL: threshold = `UFD_LVL_NFULL;
        endcase
    end

    // with fifos off the holding register acts as a one-deep fifo
    always_comb begin
        if (fifo_en) begin
            at_level = (count >= threshold);
        end else begin
            at_level = (count != 5'h00);
        end
    end
endmodule : ufd_rx_level

/* hw/ufd_dma_req.sv */
// one active-low dma request with mode-dependent set and release
`timescale 1ns/10ps
module ufd_dma_req (
    input  wire logic pclk,
    input  wire logic presetn,
    ufd_dma_if.gen    dma
);
    import ufd_pkg::*;

    ufd_req_st_t st;
    ufd_req_st_t next_st;
    logic        set_c;
    logic        drop_c;

    // scheme selection, then a two-state hold between set and release
    always_comb begin
        next_st = st;
        set_c   = (dma.mode == UFD_MODE1) ? dma.m1_set  : dma.m0_set;
        drop_c  = (dma.mode == UFD_MODE1) ? dma.m1_drop : dma.m0_drop;
        unique case (st.state)
            UFD_REQ_IDLE: begin
                if (set_c) begin
                    next_st.state = UFD_REQ_ON;
                    next_st.req_n = 1'b0;
                end
            end
            UFD_REQ_ON: begin
                if (drop_c) begin
                    next_st.state = UFD_REQ_IDLE;
                    next_st.req_n = 1'b1;
                end
            end
            default: begin
                next_st.state = UFD_REQ_IDLE;
                next_st.req_n = 1'b1;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '{state: UFD_REQ_IDLE, req_n: 1'b1};
        end else begin
            st <= next_st;
        end
    end

    assign dma.req_n = st.req_n;

    a_req_assert: assert property (
        @(posedge pclk) disable iff (!presetn)
        (st.state == UFD_REQ_IDLE && set_c) |=> !dma.req_n)
        else $error("dma request did not assert on its set condition");

    a_req_release: assert property (
        @(posedge pclk) disable iff (!presetn)
        (!dma.req_n && drop_c) |=> dma.req_n [*1] ##0 (st.state == UFD_REQ_IDLE))
        else $error("dma request did not release on its drop condition");
endmodule : ufd_dma_req

/* hw/ufd_shadow_ctrl.sv */
// apb register front end for the uart fifo control shadows
`timescale 1ns/10ps
`include "ufd_defs.svh"
module ufd_shadow_ctrl (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire ufd_pkg::ufd_cnt_t rx_fifo_count,
    input  wire ufd_pkg::ufd_cnt_t tx_fifo_count,
    output logic                   fifo_enable,
    output logic                   dma_mode,
    output logic [1:0]             rx_trigger,
    output logic                   fifo_flush,
    output logic                   rx_data_avail,
    output logic                   tx_dma_req_n,
    output logic                   rx_dma_req_n,
    output logic                   irq
);
    import ufd_pkg::*;

    ////////////////////////////////////////////////////////////////
    // state and helpers

    ufd_regs_t  st;
    ufd_regs_t  next_st;
    ufd_cnt_t   rx_thr;
    logic       at_level;
    logic       setup;
    logic       wr_go;
    logic       rd_go;
    logic       hit;
    logic [1:0] ev;
    logic [1:0] clr;
    logic [31:0] rdata;

    ufd_dma_if tx_dma ();
    ufd_dma_if rx_dma ();

    ////////////////////////////////////////////////////////////////
    // submodules

    ufd_rx_level u_level (
        .trig      (st.rx_trig),
        .fifo_en   (st.fifo_en),
        .count     (rx_fifo_count),
        .threshold (rx_thr),
        .at_level  (at_level)
    );

    ufd_dma_req u_tx_req (
        .pclk    (pclk),
        .presetn (presetn),
        .dma     (tx_dma.gen)
    );

    ufd_dma_req u_rx_req (
        .pclk    (pclk),
        .presetn (presetn),
        .dma     (rx_dma.gen)
    );

    // tx: mode 0 holds only while empty, mode 1 holds until full
    assign tx_dma.mode    = st.dma_mode;
    assign tx_dma.m0_set  = (tx_fifo_count == 5'h00);
    assign tx_dma.m0_drop = (tx_fifo_count != 5'h00);
    assign tx_dma.m1_set  = (tx_fifo_count == 5'h00);
    assign tx_dma.m1_drop = (tx_fifo_count == `UFD_DEPTH);

    // rx: mode 1 waits for the trigger level, both release on empty
    assign rx_dma.mode    = st.dma_mode;
    assign rx_dma.m0_set  = (rx_fifo_count != 5'h00);
    assign rx_dma.m0_drop = (rx_fifo_count == 5'h00);
    assign rx_dma.m1_set  = at_level;
    assign rx_dma.m1_drop = (rx_fifo_count == 5'h00);

    ////////////////////////////////////////////////////////////////
    // apb decode

    // phase terms; a transfer completes on the access edge with pready
    assign setup = psel & ~penable;
    assign wr_go = psel & penable & st.pready & pwrite;
    assign rd_go = psel & penable & st.pready & ~pwrite;

    // read mux; reserved bits stay zero
    always_comb begin
        hit   = 1'b1;
        rdata = 32'h0000_0000;
        case (paddr)
            `UFD_A_DMA_MODE: rdata[0]   = st.dma_mode;
            `UFD_A_FIFO_EN:  rdata[0]   = st.fifo_en;
            `UFD_A_RX_TRIG:  rdata[1:0] = st.rx_trig;
            `UFD_A_CTRL: begin
                rdata[`UFD_FE_BIT]   = st.fifo_en;
                rdata[`UFD_DMAM_BIT] = st.dma_mode;
                rdata[`UFD_TRIG_MSB:`UFD_TRIG_LSB] = st.rx_trig;
            end
            `UFD_A_INT_STAT: rdata[1:0] = st.int_status;
            `UFD_A_INT_MASK: rdata[1:0] = st.int_mask;
            default:         hit        = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        next_st = st;

        // one storage copy per field, reached from both windows
        if (wr_go) begin
            case (paddr)
                `UFD_A_DMA_MODE: begin
                    next_st.dma_mode = ufd_dma_mode_t'(pwdata[0]);
                end
                `UFD_A_FIFO_EN: begin
                    next_st.fifo_en = pwdata[0];
                end
                `UFD_A_RX_TRIG: begin
                    next_st.rx_trig = ufd_trig_t'(pwdata[1:0]);
                end
                `UFD_A_CTRL: begin
                    next_st.fifo_en  = pwdata[`UFD_FE_BIT];
                    next_st.dma_mode = ufd_dma_mode_t'(pwdata[`UFD_DMAM_BIT]);
                    next_st.rx_trig  =
                        ufd_trig_t'(pwdata[`UFD_TRIG_MSB:`UFD_TRIG_LSB]);
                end
                `UFD_A_INT_MASK: begin
                    next_st.int_mask = pwdata[1:0];
                end
                default: begin
                    next_st.int_mask = st.int_mask;
                end
            endcase
        end

        // events: rising onto the level, and a flush on disable
        ev[`UFD_INT_LEVEL] = at_level & ~st.was_level;
        ev[`UFD_INT_FLUSH] = st.fifo_en & ~next_st.fifo_en;

        // clear only what the reader saw at setup, so a bit that
        // lands between setup and access is not lost
        clr = (rd_go && paddr == `UFD_A_INT_STAT) ? st.prdata[1:0] : 2'h0;
        next_st.int_status = (st.int_status & ~clr) | ev;

        next_st.fifo_flush = ev[`UFD_INT_FLUSH];
        next_st.was_level  = at_level;
        next_st.rx_avail   = at_level;
        next_st.irq        = |(next_st.int_status & next_st.int_mask);

        // answer is captured in setup and shown in the access cycle
        next_st.pready  = setup;
        next_st.pslverr = setup & ~hit;
        next_st.prdata  = setup ? rdata : st.prdata;
    end

    // every field, shadows included, clears to zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////
    // outputs

    assign prdata        = st.prdata;
    assign pready        = st.pready;
    assign pslverr       = st.pslverr;
    assign fifo_enable   = st.fifo_en;
    assign dma_mode      = st.dma_mode;
    assign rx_trigger    = st.rx_trig;
    assign fifo_flush    = st.fifo_flush;
    assign rx_data_avail = st.rx_avail;
    assign tx_dma_req_n  = tx_dma.req_n;
    assign rx_dma_req_n  = rx_dma.req_n;
    assign irq           = st.irq;

    ////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_wr(logic [31:0] a);
        psel && penable && pready && pwrite && paddr == a;
    endsequence

    sequence s_rd_shadow;
        psel && penable && pready && !pwrite &&
        (paddr == `UFD_A_DMA_MODE || paddr == `UFD_A_FIFO_EN ||
         paddr == `UFD_A_RX_TRIG);
    endsequence

    sequence s_flush_pulse;
        fifo_flush ##1 !fifo_flush;
    endsequence

    a_dma_write: assert property (
        s_wr(`UFD_A_DMA_MODE) |=> dma_mode == $past(pwdata[0]))
        else $error("dma mode shadow write not stored");

    a_dma_isolated: assert property (
        s_wr(`UFD_A_DMA_MODE) |=> $stable(fifo_enable) && $stable(rx_trigger))
        else $error("dma mode write disturbed another field");

    a_fe_write: assert property (
        s_wr(`UFD_A_FIFO_EN) |=> fifo_enable == $past(pwdata[0]) &&
                                 $stable(dma_mode) && $stable(rx_trigger))
        else $error("fifo enable write wrong or not isolated");

    a_fe_flush: assert property (
        $fell(fifo_enable) |-> s_flush_pulse)
        else $error("disabling the fifos gave no single flush pulse");

    a_flush_cause: assert property (
        fifo_flush |-> $fell(fifo_enable))
        else $error("flush pulse without the fifos being disabled");

    a_trig_write: assert property (
        s_wr(`UFD_A_RX_TRIG) |=> rx_trigger == $past(pwdata[1:0]) &&
                                 $stable(dma_mode) && $stable(fifo_enable))
        else $error("rx trigger write wrong or not isolated");

    a_avail_level: assert property (
        (fifo_enable && rx_fifo_count >= rx_thr) |=> rx_data_avail)
        else $error("data available missed the trigger level");

    a_nofifo_avail: assert property (
        (!fifo_enable && rx_fifo_count != 5'h00) |=> rx_data_avail)
        else $error("with fifos off one character must flag data");

    a_trig_nfull: assert property (
        rx_trigger == 2'h3 |-> rx_thr == `UFD_DEPTH - 5'h02)
        else $error("top trigger code is not two short of full");

    a_rsvd_zero: assert property (
        s_rd_shadow |-> prdata[31:2] == 30'h0000_0000)
        else $error("reserved shadow bits read nonzero");

    a_ctrl_mirror: assert property (
        s_wr(`UFD_A_CTRL) |=> dma_mode == $past(pwdata[`UFD_DMAM_BIT]) &&
                              fifo_enable == $past(pwdata[`UFD_FE_BIT]))
        else $error("control image write not seen in the shadows");

    a_sticky_win: assert property (
        (ev[`UFD_INT_LEVEL] && clr[`UFD_INT_LEVEL]) |=>
            st.int_status[`UFD_INT_LEVEL])
        else $error("level event lost against a status clear");

    a_irq_level: assert property (
        irq == |(st.int_status & st.int_mask))
        else $error("interrupt output disagrees with masked status");

    a_apb_answer: assert property (
        (psel && !penable) |=> pready)
        else $error("setup cycle not answered in the access cycle");

    a_apb_single: assert property (
        pready |=> !pready)
        else $error("ready stood for more than one cycle");

    a_bad_addr: assert property (
        (psel && !penable && !hit) |=> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped address not refused with zero data");

    a_flush_status: assert property (
        $fell(fifo_enable) |-> st.int_status[`UFD_INT_FLUSH])
        else $error("disabling the fifos did not flag a flush");

    a_trig_one: assert property (
        rx_trigger == 2'h0 |-> rx_thr == `UFD_LVL_ONE)
        else $error("lowest trigger code is not one character");

    a_trig_qtr: assert property (
        rx_trigger == 2'h1 |-> rx_thr == `UFD_DEPTH / 5'h04)
        else $error("second trigger code is not a quarter full");

    a_trig_half: assert property (
        rx_trigger == 2'h2 |-> rx_thr == `UFD_DEPTH / 5'h02)
        else $error("third trigger code is not half full");

    a_rx_m1_set: assert property (
        (dma_mode && fifo_enable && rx_dma_req_n && rx_fifo_count >= rx_thr) |=>
            !rx_dma_req_n)
        else $error("mode 1 receive request missed the trigger level");

    a_rx_m1_hold: assert property (
        (dma_mode && fifo_enable && rx_dma_req_n && rx_fifo_count < rx_thr) |=>
            rx_dma_req_n)
        else $error("mode 1 receive request asserted below the trigger level");

    a_rx_m0_set: assert property (
        (!dma_mode && rx_dma_req_n && rx_fifo_count != 5'h00) |=> !rx_dma_req_n)
        else $error("mode 0 receive request missed a held character");

    a_tx_m1_hold: assert property (
        (dma_mode && !tx_dma_req_n && tx_fifo_count != `UFD_DEPTH) |=> !tx_dma_req_n)
        else $error("mode 1 transmit request dropped before full");

endmodule : ufd_shadow_ctrl

/* verif/ufd_fifo_model.sv */
// fifo fill model standing in for the uart datapath behind the shadows
`timescale 1ns/10ps
module ufd_fifo_model (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              flush,
    input  wire logic              load,
    input  wire ufd_pkg::ufd_cnt_t rx_set,
    input  wire ufd_pkg::ufd_cnt_t tx_set,
    output ufd_pkg::ufd_cnt_t      rx_count,
    output ufd_pkg::ufd_cnt_t      tx_count
);
    import ufd_pkg::*;
    ////////////////////////////////////////////////////////////
    // fills move only when loaded or flushed, so every level crossing is deliberate;
    // a flush pulse empties both fifos because their controllers are reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_count <= 5'h00;
            tx_count <= 5'h00;
        end else if (flush) begin
            rx_count <= 5'h00;
            tx_count <= 5'h00;
        end else if (load) begin
            rx_count <= rx_set;
            tx_count <= tx_set;
        end
    end
endmodule : ufd_fifo_model

/* verif/tb_top.sv */
// self-checking bench for the fifo control shadow registers
`timescale 1ns/10ps
`include "ufd_defs.svh"
module tb_top;
    import ufd_pkg::*;
    typedef struct packed {
        logic [31:0] wa;
        logic [31:0] wd;
        logic [31:0] ra;
        logic [31:0] re;
        logic [3:0]  flds;
    } ufd_row_t;
    localparam logic [31:0] ad_dm = `UFD_A_DMA_MODE;
    localparam logic [31:0] ad_fe = `UFD_A_FIFO_EN;
    localparam logic [31:0] ad_tr = `UFD_A_RX_TRIG;
    localparam logic [31:0] ad_ct = `UFD_A_CTRL;
    localparam logic [31:0] ad_st = `UFD_A_INT_STAT;
    localparam logic [31:0] ad_mk = `UFD_A_INT_MASK;
    localparam logic [31:0] ad_bad = 32'h5000_10A0;
    localparam ufd_cnt_t lvl [4] = '{`UFD_LVL_ONE, `UFD_LVL_QTR, `UFD_LVL_HALF, `UFD_LVL_NFULL};
    // rows: write, read back, then {enable, dma mode, trigger}
    localparam ufd_row_t rows [7] = '{
        '{ad_dm, 32'hFFFF_FFFF, ad_dm, 32'h1, 4'b0100},
        '{ad_tr, 32'h2, ad_tr, 32'h2, 4'b0110},
        '{ad_fe, 32'h1, ad_ct, 32'h89, 4'b1110},
        '{ad_ct, 32'hC1, ad_dm, 32'h0, 4'b1011},
        '{ad_tr, 32'h1, ad_ct, 32'h41, 4'b1001},
        '{ad_dm, 32'h1, ad_fe, 32'h1, 4'b1101},
        '{ad_tr, 32'h0, ad_tr, 32'h0, 4'b1100}};
    logic        pclk, presetn, psel, penable, pwrite, pslverr, pready, rerr;
    logic [31:0] paddr, pwdata, prdata, rdat;
    logic        fifo_enable, dma_mode, fifo_flush, rx_data_avail;
    logic        tx_dma_req_n, rx_dma_req_n, irq, ld;
    logic [1:0]  rx_trigger;
    ufd_cnt_t    rx_cnt, tx_cnt, rx_set, tx_set;
    int          n_errors, cmp_count, n_flush;

    ufd_shadow_ctrl u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_fifo_count(rx_cnt), .tx_fifo_count(tx_cnt),
        .fifo_enable(fifo_enable), .dma_mode(dma_mode), .rx_trigger(rx_trigger),
        .fifo_flush(fifo_flush), .rx_data_avail(rx_data_avail),
        .tx_dma_req_n(tx_dma_req_n), .rx_dma_req_n(rx_dma_req_n), .irq(irq));
    ufd_fifo_model u_fifo (
        .pclk(pclk), .presetn(presetn), .flush(fifo_flush), .load(ld),
        .rx_set(rx_set), .tx_set(tx_set), .rx_count(rx_cnt), .tx_count(tx_cnt));
    ////////////////////////////////////////////////////////////
    // clock, and a count of flush pulses seen at the sampling edges
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (fifo_flush === 1'b1) n_flush++;
    end
    ////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // one apb transfer; request held until pready is seen high at an edge
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            n_errors++;
            finish_test();
        end
    endtask : apb
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rdat, rerr);
    endtask : wr
    task automatic rd(input logic [31:0] a);
        apb(1'b0, a, 32'h0, rdat, rerr);
    endtask : rd
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask : tick
    task automatic set_cnt(input ufd_cnt_t r, input ufd_cnt_t t);
        @(posedge pclk);
        ld <= 1'b1;
        rx_set <= r;
        tx_set <= t;
        @(posedge pclk);
        ld <= 1'b0;
    endtask : set_cnt
    ////////////////////////////////////////////////////////////
    // main sequence: reset, table rows, then levels, modes, flush and refusals
    initial begin
        {presetn, psel, penable, pwrite, ld} = 5'h0;
        {paddr, pwdata} = 64'h0;
        {rx_set, tx_set} = 10'h0;
        n_errors = 0;
        cmp_count = 0;
        n_flush = 0;
        tick(3);
        chk("reset outputs", 32'h006, {fifo_enable, dma_mode, rx_trigger, fifo_flush,
            rx_data_avail, tx_dma_req_n, rx_dma_req_n, irq});
        presetn <= 1'b1;
        foreach (lvl[k]) begin
            if (k < 3) begin
                rd(ad_dm + 4 * k);
                chk("reset shadow", 32'h0, rdat);
            end
        end
        $display("test reset done");
        foreach (rows[i]) begin
            wr(rows[i].wa, rows[i].wd);
            rd(rows[i].ra);
            chk("readback", rows[i].re, rdat);
            chk("fields", rows[i].flds, {fifo_enable, dma_mode, rx_trigger});
        end
        chk("no flush", 32'h0, n_flush);
        $display("test rows done");
        // mode 1: each trigger code checked one below and at its level
        for (int k = 0; k < 4; k++) begin
            wr(ad_tr, k);
            set_cnt(lvl[k] - 5'h01, 5'h00);
            tick(2);
            chk("below level", 32'h1, {rx_data_avail, rx_dma_req_n});
            set_cnt(lvl[k], 5'h00);
            tick(2);
            chk("at level", 32'h2, {rx_data_avail, rx_dma_req_n});
            set_cnt(5'h00, 5'h00);
            tick(2);
        end
        set_cnt(5'h00, 5'h05);
        tick(2);
        chk("mode 1 tx held", 32'h0, tx_dma_req_n);
        set_cnt(5'h00, `UFD_DEPTH);
        tick(2);
        chk("mode 1 tx full", 32'h1, tx_dma_req_n);
        $display("test levels done");
        wr(ad_dm, 32'h0);
        wr(ad_tr, 32'h3);
        set_cnt(5'h01, 5'h05);
        tick(2);
        chk("mode 0 filled", 32'h1, {rx_data_avail, rx_dma_req_n, tx_dma_req_n});
        set_cnt(5'h00, 5'h00);
        tick(2);
        chk("mode 0 empty", 32'h2, {rx_data_avail, rx_dma_req_n, tx_dma_req_n});
        $display("test mode 0 done");
        // disable with data held: flush pulse, unmasked interrupt, read clears
        wr(ad_mk, 32'h2);
        set_cnt(5'h05, 5'h05);
        wr(ad_fe, 32'h0);
        tick(4);
        chk("flush count", 32'h1, n_flush);
        chk("flush irq", 32'h1, {fifo_enable, irq});
        rd(ad_st);
        chk("flush status", 32'h2, rdat & 32'h2);
        tick(3);
        chk("irq cleared", 32'h0, irq);
        set_cnt(5'h01, 5'h00);
        tick(2);
        chk("fifo off level", 32'h1, rx_data_avail);
        wr(ad_mk, 32'h0);
        wr(ad_fe, 32'h1);
        wr(ad_fe, 32'h0);
        tick(4);
        chk("masked irq", 32'h0, irq);
        chk("second flush", 32'h2, n_flush);
        rd(ad_st);
        chk("masked status", 32'h2, rdat & 32'h2);
        $display("test flush done");
        apb(1'b1, ad_bad, 32'hFFFF_FFFF, rdat, rerr);
        chk("bad write err", 32'h1, rerr);
        apb(1'b0, ad_bad, 32'h0, rdat, rerr);
        chk("bad read data", 32'h0, rdat);
        chk("bad read err", 32'h1, rerr);
        chk("fields kept", 32'h3, {fifo_enable, dma_mode, rx_trigger});
        $display("test unmapped done");
        // a level event landing on the clearing read must survive it
        set_cnt(5'h01, 5'h00);
        set_cnt(5'h00, 5'h00);
        fork
            rd(ad_st);
            set_cnt(5'h01, 5'h00);
        join
        chk("status seen", 32'h1, rdat & 32'h1);
        rd(ad_st);
        chk("set beats clear", 32'h1, rdat & 32'h1);
        $display("test set beats clear done");
        finish_test();
    end
endmodule : tb_top
